/* File: rds_defs.svh */
// constants for the ramp and direction select block
//
// Functional notes
// - terminal mode: fn64 set three, fn5 two
// - combined mode: switching frequencies plus fn5 pick set
// - direction limit: 0 both, 1 no reverse, 2 no forward
// - stop 0: ramp down, then dc brake if valid
// - stop 1: coast when commanded from keypad
// - stop 2 coast two-wire, 3 coast three-wire
// - never dc brake during coasting stop
// - non-coast stop ramps down then stops
// - priority 0: both commands run reverse; default 1
// - priority 1: both commands stop motor
// - priority 2: follow first asserted command
// - priority 3: follow later asserted command
// - regen: 0 off, 1 with protection, 2 without
// - reversal while running pauses for dead time
// - run removed before direction change: no pause
// - jog direction change never pauses
// - analog curve two zero start skips dead time
// - analog zero keeps direction, same-direction restart immediate
// - panel protocol 0 standard, 1 display variant
// - set three arcs 0 to 50, default 10
`ifndef RDS_DEFS_SVH
`define RDS_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RDS_A_CTRL   12'h000
`define RDS_A_FREQ   12'h004
`define RDS_A_DEAD   12'h008
`define RDS_A_SCRV   12'h00c
`define RDS_A_STAT   12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RDS_F_LIM    0
`define RDS_F_STOP   2
`define RDS_F_PRIO   4
`define RDS_F_REGEN  8
`define RDS_F_PROTO  12
`define RDS_F_RMODE  16
`define RDS_F_RFIX   20
`define RDS_F_FSW2   16
`define RDS_F_SCHI   8

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define RDS_R_LIM    2'h0
`define RDS_R_STOP   2'h2
`define RDS_R_PRIO   3'h1
`define RDS_R_REGEN  2'h2
`define RDS_R_PROTO  1'h0
`define RDS_R_RMODE  2'h1
`define RDS_R_RFIX   2'h1
`define RDS_R_DEAD   8'h00
`define RDS_R_SC     6'h0a
`define RDS_MAX_SC   6'h32
`define RDS_MAX_DEAD 8'hfa

// ----------------------------------------------------------------
// ramp sets, modes and timing
// ----------------------------------------------------------------
`define RDS_SET1     2'h1
`define RDS_SET2     2'h2
`define RDS_SET3     2'h3
`define RDS_RM_FIXED 2'h0
`define RDS_RM_TERM  2'h1
`define RDS_RM_COMB  2'h2
`define RDS_TENTH_NS 100000000
`define RDS_CLK_NS   40

`endif

/* File: rds_pkg.sv */
// types for the ramp and direction select block
package rds_pkg;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_RUN    = 5'h02,
        ST_REVDEC = 5'h04,
        ST_DWELL  = 5'h08,
        ST_STOP   = 5'h10
    } rds_state_type;

    typedef enum logic [1:0] {
        SRC_KEYPAD     = 2'h0,
        SRC_TWO_WIRE   = 2'h1,
        SRC_THREE_WIRE = 2'h2,
        SRC_OTHER      = 2'h3
    } rds_src_type;

    typedef struct packed {
        rds_state_type st;
        logic          dir;
        logic          run;
        logic          coast;
        logic          dc;
        logic          dwell;
        logic [1:0]    ramp_set;
        logic          f_d;
        logic          r_d;
        logic          first_rev;
        logic          last_rev;
        logic [7:0]    cnt;
        logic [31:0]   tick;
        logic [1:0]    lim;
        logic [1:0]    stop;
        logic [2:0]    prio;
        logic [1:0]    regen;
        logic          proto;
        logic [1:0]    rmode;
        logic [1:0]    rfix;
        logic [15:0]   fsw1;
        logic [15:0]   fsw2;
        logic [7:0]    dead;
        logic [5:0]    sc_lo;
        logic [5:0]    sc_hi;
        logic          regen_en;
        logic          ovl_prot;
        logic          pready;
        logic          pslverr;
        logic [31:0]   prdata;
    } rds_main_type;

endpackage

/* File: rds_sync.sv */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module rds_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } rds_sync_type;

    rds_sync_type s_q;
    rds_sync_type s_d;

    // first stage feeds only the second stage
    always_comb
    begin
        s_d.meta = din;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dout = s_q.sync;
endmodule // rds_sync
`default_nettype wire

/* File: rds_top.sv */
// ramp set, direction arbitration and stop method control
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "rds_defs.svh"
module rds_top #(
    parameter int unsigned TENTH_CYCLES = `RDS_TENTH_NS / `RDS_CLK_NS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fwd_cmd_in,
    input  wire logic        rev_cmd_in,
    input  wire logic        jog_in,
    input  wire logic        acc_sel_fn5_in,
    input  wire logic        acc_sel_fn64_in,
    input  wire logic [1:0]  cmd_source,
    input  wire logic [15:0] commanded_freq,
    input  wire logic        output_at_zero,
    input  wire logic        analog_curve2,
    input  wire logic        dc_brake_valid,
    output logic [1:0]       ramp_set,
    output logic             run_enable,
    output logic             run_reverse,
    output logic             coast_stop,
    output logic             dc_brake_req,
    output logic             dead_time_active,
    output logic             regen_brake_en,
    output logic             brake_ovl_prot_en,
    output logic             panel_port_protocol,
    output logic [5:0]       scurve_low_arc_set3,
    output logic [5:0]       scurve_high_arc_set3
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (TENTH_CYCLES < 2)
    begin : g_bad_tenth
        $error("TENTH_CYCLES must be at least 2");
    end

    localparam logic [31:0] TENTH_LAST = 32'(TENTH_CYCLES - 1);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_s;

    rds_sync #(
        .WIDTH (5)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({jog_in, acc_sel_fn64_in, acc_sel_fn5_in, rev_cmd_in, fwd_cmd_in}),
        .dout    (pins_s)
    );

    logic sf;
    logic sr;
    logic fn5;
    logic fn64;
    logic jog;
    assign sf   = pins_s[0];
    assign sr   = pins_s[1];
    assign fn5  = pins_s[2];
    assign fn64 = pins_s[3];
    assign jog  = pins_s[4];

    rds_pkg::rds_main_type s_q;
    rds_pkg::rds_main_type s_d;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic wv;
    logic wd;
    logic coast_sel;
    logic zero_f;
    logic acc;
    logic [11:0] woff;

    always_comb
    begin
        if (sf && sr)
        begin
            unique case (s_q.prio)
                3'h0:    begin wv = 1'b1; wd = 1'b1; end
                3'h2:    begin wv = 1'b1; wd = s_q.first_rev; end
                3'h3:    begin wv = 1'b1; wd = s_q.last_rev; end
                default: begin wv = 1'b0; wd = 1'b0; end
            endcase
        end
        else
        begin
            wv = sf || sr;
            wd = sr;
        end
        if (wv && ((s_q.lim == 2'h1 && wd) || (s_q.lim == 2'h2 && !wd)))
            wv = 1'b0;
        coast_sel = (s_q.stop == 2'h1 && cmd_source == rds_pkg::SRC_KEYPAD)
                 || (s_q.stop == 2'h2 && cmd_source == rds_pkg::SRC_TWO_WIRE)
                 || (s_q.stop == 2'h3 && cmd_source == rds_pkg::SRC_THREE_WIRE);
        zero_f = (commanded_freq == 16'h0000);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.f_d = sf;
        s_d.r_d = sr;
        // arrival order of the two run commands
        if (sf && !s_q.f_d && !sr)
            s_d.first_rev = 1'b0;
        if (sr && !s_q.r_d && !sf)
            s_d.first_rev = 1'b1;
        if (sr && !s_q.r_d)
            s_d.last_rev = 1'b1;
        else if (sf && !s_q.f_d)
            s_d.last_rev = 1'b0;

        // ramp set choice
        unique case (s_q.rmode)
            `RDS_RM_TERM:
                s_d.ramp_set = fn64 ? `RDS_SET3 : (fn5 ? `RDS_SET2 : `RDS_SET1);
            `RDS_RM_COMB:
            begin
                if (commanded_freq <= s_q.fsw1)
                    s_d.ramp_set = fn5 ? `RDS_SET2 : `RDS_SET1;
                else if (commanded_freq <= s_q.fsw2)
                    s_d.ramp_set = fn5 ? `RDS_SET1 : `RDS_SET2;
                else
                    s_d.ramp_set = `RDS_SET3;
            end
            default:
                s_d.ramp_set = (s_q.rfix == 2'h0) ? `RDS_SET1 : s_q.rfix;
        endcase

        s_d.regen_en = (s_q.regen != 2'h0);
        s_d.ovl_prot = (s_q.regen == 2'h1);

        unique case (s_q.st)
            rds_pkg::ST_IDLE:
            begin
                // a fresh start never waits: run was removed first
                if (wv)
                begin
                    s_d.st = rds_pkg::ST_RUN;
                    s_d.run = 1'b1;
                    s_d.dir = wd;
                    s_d.coast = 1'b0;
                    s_d.dc = 1'b0;
                end
            end
            rds_pkg::ST_RUN:
            begin
                if (!wv)
                begin
                    s_d.st = rds_pkg::ST_STOP;
                    s_d.run = 1'b0;
                    s_d.coast = coast_sel;
                end
                else if (wd != s_q.dir)
                begin
                    if (jog || (analog_curve2 && zero_f))
                        s_d.dir = wd;
                    else
                    begin
                        s_d.st = rds_pkg::ST_REVDEC;
                        s_d.run = 1'b0;
                    end
                end
            end
            rds_pkg::ST_REVDEC:
            begin
                if (!wv)
                begin
                    s_d.st = rds_pkg::ST_STOP;
                    s_d.coast = coast_sel;
                end
                else if (wd == s_q.dir)
                begin
                    s_d.st = rds_pkg::ST_RUN;
                    s_d.run = 1'b1;
                end
                else if (output_at_zero)
                begin
                    if (s_q.dead == 8'h00)
                    begin
                        s_d.st = rds_pkg::ST_RUN;
                        s_d.run = 1'b1;
                        s_d.dir = wd;
                    end
                    else
                    begin
                        s_d.st = rds_pkg::ST_DWELL;
                        s_d.cnt = s_q.dead;
                        s_d.tick = 32'h0;
                    end
                end
            end
            rds_pkg::ST_DWELL:
            begin
                if (!wv)
                begin
                    s_d.st = rds_pkg::ST_STOP;
                    s_d.coast = coast_sel;
                end
                else if (wd == s_q.dir)
                begin
                    s_d.st = rds_pkg::ST_RUN;
                    s_d.run = 1'b1;
                end
                else if (s_q.tick == TENTH_LAST)
                begin
                    s_d.tick = 32'h0;
                    s_d.cnt = s_q.cnt - 8'h01;
                    if (s_q.cnt == 8'h01)
                    begin
                        s_d.st = rds_pkg::ST_RUN;
                        s_d.run = 1'b1;
                        s_d.dir = wd;
                    end
                end
                else
                    s_d.tick = s_q.tick + 32'h1;
            end
            rds_pkg::ST_STOP:
            begin
                // coasting drops output at once, dc braking stays off
                if (s_q.coast)
                begin
                    s_d.st = rds_pkg::ST_IDLE;
                    s_d.dc = 1'b0;
                end
                else if (wv)
                begin
                    s_d.st = rds_pkg::ST_RUN;
                    s_d.run = 1'b1;
                    s_d.dir = wd;
                end
                else if (output_at_zero)
                begin
                    s_d.st = rds_pkg::ST_IDLE;
                    s_d.dc = (s_q.stop == 2'h0) && dc_brake_valid;
                end
            end
        endcase
        s_d.dwell = (s_d.st == rds_pkg::ST_DWELL);

        // ------------------------------------------------------------
        // apb slave: one wait-free access, answer prepared in setup
        // ------------------------------------------------------------
        acc = psel && penable && s_q.pready;
        woff = paddr;
        s_d.pready = psel && !penable;
        if (psel && !penable)
        begin
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h0;
            unique case (paddr)
                `RDS_A_CTRL:
                begin
                    s_d.prdata[`RDS_F_LIM +: 2] = s_q.lim;
                    s_d.prdata[`RDS_F_STOP +: 2] = s_q.stop;
                    s_d.prdata[`RDS_F_PRIO +: 3] = s_q.prio;
                    s_d.prdata[`RDS_F_REGEN +: 2] = s_q.regen;
                    s_d.prdata[`RDS_F_PROTO] = s_q.proto;
                    s_d.prdata[`RDS_F_RMODE +: 2] = s_q.rmode;
                    s_d.prdata[`RDS_F_RFIX +: 2] = s_q.rfix;
                end
                `RDS_A_FREQ: s_d.prdata = {s_q.fsw2, s_q.fsw1};
                `RDS_A_DEAD: s_d.prdata[7:0] = s_q.dead;
                `RDS_A_SCRV:
                begin
                    s_d.prdata[5:0] = s_q.sc_lo;
                    s_d.prdata[`RDS_F_SCHI +: 6] = s_q.sc_hi;
                end
                `RDS_A_STAT:
                    s_d.prdata[15:0] = {s_q.cnt, s_q.st, s_q.dir, s_q.ramp_set};
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (acc && pwrite && !s_q.pslverr)
        begin
            unique case (woff)
                `RDS_A_CTRL:
                begin
                    s_d.lim = pwdata[`RDS_F_LIM +: 2];
                    s_d.stop = pwdata[`RDS_F_STOP +: 2];
                    s_d.prio = pwdata[`RDS_F_PRIO +: 3];
                    s_d.regen = pwdata[`RDS_F_REGEN +: 2];
                    s_d.proto = pwdata[`RDS_F_PROTO];
                    s_d.rmode = pwdata[`RDS_F_RMODE +: 2];
                    s_d.rfix = pwdata[`RDS_F_RFIX +: 2];
                end
                `RDS_A_FREQ:
                begin
                    s_d.fsw1 = pwdata[15:0];
                    s_d.fsw2 = pwdata[`RDS_F_FSW2 +: 16];
                end
                `RDS_A_DEAD:
                    s_d.dead = (pwdata[7:0] > `RDS_MAX_DEAD) ? `RDS_MAX_DEAD : pwdata[7:0];
                `RDS_A_SCRV:
                begin
                    // out-of-range arcs saturate rather than wrap
                    s_d.sc_lo = (pwdata[5:0] > `RDS_MAX_SC) ? `RDS_MAX_SC : pwdata[5:0];
                    s_d.sc_hi = (pwdata[`RDS_F_SCHI +: 6] > `RDS_MAX_SC)
                              ? `RDS_MAX_SC : pwdata[`RDS_F_SCHI +: 6];
                end
                default: s_d.stop = s_q.stop;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.st <= rds_pkg::ST_IDLE;
            s_q.ramp_set <= `RDS_SET1;
            s_q.lim <= `RDS_R_LIM;
            s_q.stop <= `RDS_R_STOP;
            s_q.prio <= `RDS_R_PRIO;
            s_q.regen <= `RDS_R_REGEN;
            s_q.proto <= `RDS_R_PROTO;
            s_q.rmode <= `RDS_R_RMODE;
            s_q.rfix <= `RDS_R_RFIX;
            s_q.dead <= `RDS_R_DEAD;
            s_q.sc_lo <= `RDS_R_SC;
            s_q.sc_hi <= `RDS_R_SC;
        end
        else
            s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign ramp_set = s_q.ramp_set;
    assign run_enable = s_q.run;
    assign run_reverse = s_q.dir;
    assign coast_stop = s_q.coast;
    assign dc_brake_req = s_q.dc;
    assign dead_time_active = s_q.dwell;
    assign regen_brake_en = s_q.regen_en;
    assign brake_ovl_prot_en = s_q.ovl_prot;
    assign panel_port_protocol = s_q.proto;
    assign scurve_low_arc_set3 = s_q.sc_lo;
    assign scurve_high_arc_set3 = s_q.sc_hi;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_term_set3;
        (s_q.rmode == `RDS_RM_TERM && fn64) |=> (ramp_set == `RDS_SET3);
    endproperty
    a_term_set3: assert property (p_term_set3) else $error("fn64 not set three");

    property p_comb_high;
        (s_q.rmode == `RDS_RM_COMB && commanded_freq > s_q.fsw2) |=> (ramp_set == `RDS_SET3);
    endproperty
    a_comb_high: assert property (p_comb_high) else $error("high freq not set three");

    property p_no_rev;
        (s_q.lim == 2'h1)[*2] |-> !(run_enable && run_reverse);
    endproperty
    a_no_rev: assert property (p_no_rev) else $error("reverse ran while blocked");

    property p_coast_no_dc;
        coast_stop |-> !dc_brake_req;
    endproperty
    a_coast_no_dc: assert property (p_coast_no_dc) else $error("dc brake in coast");

    property p_both_stop;
        (s_q.prio == 3'h1 && sf && sr) |=> !run_enable;
    endproperty
    a_both_stop: assert property (p_both_stop) else $error("both commands kept running");

    property p_regen;
        (s_q.regen == 2'h1) |=> (regen_brake_en && brake_ovl_prot_en);
    endproperty
    a_regen: assert property (p_regen) else $error("regen decode wrong");

    property p_dwell_idle;
        dead_time_active |-> !run_enable && s_q.cnt != 8'h00;
    endproperty
    a_dwell_idle: assert property (p_dwell_idle) else $error("output during dead time");

    property p_jog_swap;
        (s_q.st == rds_pkg::ST_RUN && jog && wv && wd != s_q.dir)
            |=> run_enable && run_reverse == $past(wd) && !dead_time_active;
    endproperty
    a_jog_swap: assert property (p_jog_swap) else $error("jog reversal paused");

    property p_tick;
        (dead_time_active && s_q.tick == TENTH_LAST && s_q.cnt > 8'h01 && wv
            && wd != s_q.dir) |=> (s_q.cnt == $past(s_q.cnt) - 8'h01);
    endproperty
    a_tick: assert property (p_tick) else $error("dead time count slipped");

    property p_arcs;
        scurve_low_arc_set3 <= `RDS_MAX_SC && scurve_high_arc_set3 <= `RDS_MAX_SC;
    endproperty
    a_arcs: assert property (p_arcs) else $error("arc beyond fifty");

    c_dwell: cover property ($rose(dead_time_active));
    c_coast: cover property ($rose(coast_stop));
    c_dc: cover property ($rose(dc_brake_req));
    c_rev_run: cover property (dead_time_active ##1 run_enable);
endmodule // rds_top
`default_nettype wire

/* File: rds_ramp_model.sv */
// stand-in for the ramp generator on the far side of the run outputs
`timescale 1ns/100ps
`default_nettype none
module rds_ramp_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run_enable,
    output var logic  output_at_zero
);
    logic [1:0] dec_q;
    // a few cycles of deceleration so that stop and reversal really wait
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dec_q <= 2'h0;
            output_at_zero <= 1'b1;
        end
        else if (run_enable)
        begin
            dec_q <= 2'h0;
            output_at_zero <= 1'b0;
        end
        else
        begin
            dec_q <= (dec_q == 2'h3) ? dec_q : dec_q + 2'h1;
            output_at_zero <= (dec_q == 2'h3);
        end
    end
endmodule // rds_ramp_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the ramp and direction select block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, output_at_zero;
    logic        fwd_cmd_in = 1'b0, rev_cmd_in = 1'b0, jog_in = 1'b0, analog_curve2 = 1'b0;
    logic        acc_sel_fn5_in = 1'b0, acc_sel_fn64_in = 1'b0, dc_brake_valid = 1'b0;
    logic [1:0]  cmd_source = 2'h0, ramp_set;
    logic [15:0] commanded_freq = 16'h0;
    logic        run_enable, run_reverse, coast_stop, dc_brake_req, dead_time_active;
    logic        regen_brake_en, brake_ovl_prot_en, panel_port_protocol;
    logic [5:0]  scurve_low_arc_set3, scurve_high_arc_set3;
    int          errors = 0, samples_checked = 0, cyc = 0, n;

    always #20 pclk = ~pclk;

    rds_top #(.TENTH_CYCLES(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fwd_cmd_in, .rev_cmd_in, .jog_in, .acc_sel_fn5_in,
        .acc_sel_fn64_in, .cmd_source, .commanded_freq, .output_at_zero, .analog_curve2,
        .dc_brake_valid, .ramp_set, .run_enable, .run_reverse, .coast_stop, .dc_brake_req,
        .dead_time_active, .regen_brake_en, .brake_ovl_prot_en, .panel_port_protocol,
        .scurve_low_arc_set3, .scurve_high_arc_set3);
    rds_ramp_model i_ramp (.pclk, .presetn, .run_enable, .output_at_zero);

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // read data and error are taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        chk(k < 20, 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pins(input logic f, input logic r, input int idle);
        @(posedge pclk);
        fwd_cmd_in <= f;
        rev_cmd_in <= r;
        repeat (idle) @(negedge pclk);
    endtask
    // waits for run_enable (0) or dead_time_active (1), counting negedges in n
    task automatic wait_for(input int s, input logic v);
        n = 0;
        do @(negedge pclk); while ((s == 0 ? run_enable : dead_time_active) !== v && ++n < 300);
        chk(n < 300, 1'b1);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h0011_0218);
        chk({regen_brake_en, brake_ovl_prot_en, panel_port_protocol}, 3'h4);
        apb(1'b1, 12'h000, 32'h0011_1118);
        repeat (2) @(negedge pclk);
        chk({regen_brake_en, brake_ovl_prot_en, panel_port_protocol}, 3'h7);
        apb(1'b1, 12'h000, 32'h0011_0018);
        repeat (2) @(negedge pclk);
        chk({regen_brake_en, brake_ovl_prot_en}, 2'h0);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0000_0a0a);
        apb(1'b1, 12'h00c, 32'h0000_3f3f);
        apb(1'b0, 12'h00c, 32'h0);
        chk({rd[15:0], scurve_high_arc_set3, scurve_low_arc_set3}, 28'h3232cb2);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        $display("test regs done");
    endtask
    task automatic t_ramp;
        apb(1'b1, 12'h004, 32'h00c8_0064);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, 12'h000, m == 0 ? 32'h0011_0218 : 32'h0012_0218);
            for (int i = 0; i < 4; i++)
            begin
                @(posedge pclk);
                acc_sel_fn5_in <= i[0];
                acc_sel_fn64_in <= i[1];
                commanded_freq <= (m == 0) ? 16'd50 : 16'd100 * m[15:0] - 16'd50;
                repeat (5) @(negedge pclk);
                if (m == 0)
                    chk(ramp_set, i[1] ? 2'h3 : i[0] ? 2'h2 : 2'h1);
                else
                    chk(ramp_set, m == 3 ? 2'h3 : (i[0] ^ (m == 2)) ? 2'h2 : 2'h1);
            end
        end
        $display("test ramp done");
    endtask
    task automatic t_rev;
        apb(1'b1, 12'h008, 32'h2);
        pins(1'b1, 1'b0, 0);
        wait_for(0, 1'b1);
        chk(run_reverse, 1'b0);
        pins(1'b0, 1'b1, 0);
        wait_for(0, 1'b0);
        wait_for(1, 1'b1);
        wait_for(0, 1'b1);
        chk(n, 2 * 4 - 1);
        chk({run_reverse, dead_time_active}, 2'h2);
        pins(1'b0, 1'b0, 12);
        pins(1'b1, 1'b0, 0);
        wait_for(0, 1'b1);
        chk(n <= 4 && dead_time_active === 1'b0, 1'b1);
        pins(1'b1, 1'b0, 0);
        jog_in <= 1'b1;
        pins(1'b0, 1'b1, 8);
        chk({run_enable, run_reverse, dead_time_active}, 3'h6);
        pins(1'b0, 1'b0, 12);
        $display("test reversal done");
    endtask
    task automatic t_prio;
        pins(1'b1, 1'b1, 8);
        chk(run_enable, 1'b0);
        pins(1'b0, 1'b0, 4);
        apb(1'b1, 12'h000, 32'h0011_0208);
        pins(1'b1, 1'b1, 0);
        wait_for(0, 1'b1);
        chk(run_reverse, 1'b1);
        pins(1'b0, 1'b0, 12);
        apb(1'b1, 12'h000, 32'h0011_0219);
        pins(1'b0, 1'b1, 8);
        chk(run_enable, 1'b0);
        pins(1'b0, 1'b0, 4);
        $display("test priority done");
    endtask
    task automatic t_stop;
        apb(1'b1, 12'h000, 32'h0011_0218);
        cmd_source <= 2'h1;
        dc_brake_valid <= 1'b1;
        pins(1'b1, 1'b0, 0);
        wait_for(0, 1'b1);
        pins(1'b0, 1'b0, 0);
        wait_for(0, 1'b0);
        chk(coast_stop, 1'b1);
        repeat (8) @(negedge pclk);
        chk(dc_brake_req, 1'b0);
        apb(1'b1, 12'h000, 32'h0011_0210);
        pins(1'b1, 1'b0, 0);
        wait_for(0, 1'b1);
        pins(1'b0, 1'b0, 0);
        wait_for(0, 1'b0);
        chk({coast_stop, dc_brake_req}, 2'h0);
        repeat (8) @(negedge pclk);
        chk(dc_brake_req, 1'b1);
        $display("test stop done");
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            $display("mismatch at %0t: run did not finish", $time);
            give_verdict;
        end
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_ramp;
        t_rev;
        t_prio;
        t_stop;
        give_verdict;
    end
endmodule // tb_top
`default_nettype wire
